// ### rtl/dmalc_top.sv
// 64-channel controller with linking, chaining and ping-pong buffer
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - a finished channel with chaining on triggers its chosen next channel.
// - the link field is 16 bits and holds a byte offset of the next set.
// - a reloaded set waits for a new trigger with no software action.
// - sets 0 to 63 belong one to one to the 64 channels.
// - links may reach sets beyond 63, up to 128 or 256 per instance.
// - a channel starts on hardware event, software write or chain.
// - the sample buffer has two 32KB halves, one written, one read.
// - after the set chirp count the half swaps and chirp-ready is raised.
// - chirp-ready may trigger a channel that interrupts on completion.
// - in direct-read mode each half shrinks to 16 kB.
// - samples of each rx channel over all chirps sit contiguously.
// - the bulk port is 128 bits, 16 contiguous bytes per beat.
// - transfers have array bytes, arrays with strides and frames.
// - two instances, each with two transfer controllers, give four.
module dmalc_top
   import dmalc_pkg::*;
#(
   parameter int unsigned SETS   = SETS_A,
   parameter int unsigned CHIRP_SAMPLES = 256
) (
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   input  wire dmalc_pkg::dmalc_bus_type bus,
   output      logic [31:0]             rdata,
   input  wire dmalc_pkg::dmalc_sample_type sample,
   input  wire logic                    hw_event,
   input  wire logic                    mem_ready,
   output      dmalc_pkg::dmalc_mem_req_type mem_req,
   output      logic [12:0]             buf_waddr,
   output      logic [31:0]             buf_wdata,
   output      logic                    buf_we,
   output      logic                    write_half,
   output      logic                    chirp_ready,
   output      logic                    irq
);
   import dmalc_pkg::*;
   localparam int unsigned SW = $clog2(SETS);
   localparam int unsigned ASTEP = BULK_W / 8;

   typedef struct packed {
      logic [31:0]          rdata;
      logic [CHANNELS-1:0]  pend;
      logic [CHANNELS-1:0]  status;
      logic [CHANNELS-1:0]  mask;
      logic [5:0]           evsel;
      logic                 direct;
      logic [7:0]           chirps;
      logic [7:0]           chirp_cnt;
      logic [10:0]          samp_cnt;
      logic                 half;
      logic                 chirp_ready;
      logic [1:0]           xfer_owner;
      dmalc_state_type      state;
      logic [5:0]           chan;
      logic [2:0]           word;
      logic [31:0]          src;
      logic [31:0]          dst;
      logic [15:0]          array_byte_count;
      logic [15:0]          array_count;
      logic [15:0]          frame_count;
      logic [15:0]          arem;
      logic [15:0]          brem;
      logic [31:0]          src_b;
      logic [31:0]          dst_b;
      dmalc_mem_req_type    mem_req;
      logic [12:0]          buf_waddr;
      logic [31:0]          buf_wdata;
      logic                 buf_we;
      logic                 irq;
   } dmalc_regs_type;

   dmalc_regs_type r;
   dmalc_regs_type next_r;
   logic [31:0] parameter_table [SETS*8];
   logic [31:0] pword [8];
   logic [5:0]  pick;
   logic        any_pend;
   logic        pwr;
   logic [SW-1:0] pset;
   logic [SW-1:0] link_set;
   logic          reload;

   //////////////////////////////////////////////////////////////////////////
   // parameter memory, also written by the reload copy
   assign pwr = bus.write && bus.addr[11];
   assign pset = SW'(bus.addr[10:5]);
   assign link_set = SW'(pword[W_LINK][LINK_W-1:0] / SET_BYTES);
   assign reload = (r.state == DONE) && (pword[W_LINK][15:0] != LINK_NULL);
   // one process owns the memory: host write wins over a reload copy
   always_ff @(posedge core_clk) begin
      if (pwr) begin
         parameter_table[{pset, bus.addr[4:2]}] <= bus.wdata;
      end else if (reload) begin
         for (int w = 0; w < 8; w++) begin
            parameter_table[{SW'(r.chan), 3'(w)}] <= parameter_table[{link_set, 3'(w)}];
         end
      end
   end
   generate
      for (genvar w = 0; w < 8; w++) begin : g_rd
         assign pword[w] = parameter_table[{SW'(r.chan), 3'(w)}];
      end
   endgenerate

   always_comb begin
      pick = 6'h00;
      any_pend = 1'b0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         if (r.pend[i]) begin
            pick = 6'(i);
            any_pend = 1'b1;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      next_r.rdata = 32'h0000_0000;
      next_r.buf_we = 1'b0;
      next_r.chirp_ready = 1'b0;
      // register reads
      if (bus.read) begin
         unique case (bus.addr)
            OFS_STATUS:  next_r.rdata = r.status[31:0];
            OFS_MASK:    next_r.rdata = r.mask[31:0];
            OFS_EVSEL:   next_r.rdata = {26'h0, r.evsel};
            OFS_BUFCTL:  next_r.rdata = {23'h0, r.direct, r.chirps};
            OFS_BUFSTAT: next_r.rdata = {23'h0, r.half, r.chirp_cnt};
            OFS_ACTIVE:  next_r.rdata = {24'h0, r.state, r.chan};
            default: begin
               if (bus.addr[11]) begin
                  next_r.rdata = parameter_table[{pset, bus.addr[4:2]}];
               end
            end
         endcase
      end
      if (bus.write) begin
         unique case (bus.addr)
            OFS_STATUS: next_r.status = r.status & ~{32'h0, bus.wdata};
            OFS_MASK:   next_r.mask = {32'h0, bus.wdata};
            OFS_EVSEL:  next_r.evsel = bus.wdata[5:0];
            OFS_BUFCTL: begin
               next_r.chirps = bus.wdata[7:0];
               next_r.direct = bus.wdata[8];
            end
            OFS_SWTRIG: next_r.pend = r.pend | (64'h1 << bus.wdata[5:0]);
            default: ;
         endcase
      end
      if (sample.valid) begin
         next_r.buf_we = 1'b1;
         next_r.buf_wdata = sample.data;
         next_r.buf_waddr = 13'((({5'h0, sample.rx} * r.chirps
            + {2'h0, r.chirp_cnt}) * CHIRP_SAMPLES + r.samp_cnt)
            & (r.direct ? 13'h0fff : 13'h1fff));
         next_r.samp_cnt = r.samp_cnt + 11'h001;
         if (sample.last_of_chirp) begin
            next_r.samp_cnt = 11'h000;
            next_r.chirp_cnt = r.chirp_cnt + 8'h01;
            if (r.chirp_cnt + 8'h01 >= r.chirps) begin
               next_r.chirp_cnt = 8'h00;
               next_r.half = ~r.half;
               next_r.chirp_ready = 1'b1;
            end
         end
      end
      if (r.chirp_ready || hw_event) begin
         next_r.pend[r.evsel] = 1'b1;
      end
      unique case (r.state)
         IDLE: if (any_pend) begin
            next_r.chan = pick;
            next_r.pend[pick] = 1'b0;
            next_r.state = LOAD;
         end
         LOAD: begin
            next_r.src = pword[W_SRC];
            next_r.dst = pword[W_DST];
            next_r.array_byte_count = pword[W_CNT][15:0];
            next_r.array_count = pword[W_CNT][31:16];
            next_r.frame_count = pword[W_FRM][15:0];
            next_r.arem = pword[W_CNT][15:0];
            next_r.brem = pword[W_CNT][31:16];
            next_r.src_b = pword[W_SRC];
            next_r.dst_b = pword[W_DST];
            next_r.state = MOVE;
         end
         MOVE: begin
            next_r.mem_req.valid = 1'b1;
            next_r.mem_req.write = 1'b0;
            next_r.mem_req.addr = r.src;
            next_r.mem_req.byte_en = 16'hffff;
            next_r.mem_req.data = {96'h0, r.dst};
            if (r.mem_req.valid && mem_ready) begin
               if (r.arem > 16'(ASTEP)) begin
                  next_r.arem = r.arem - 16'(ASTEP);
                  next_r.src = r.src + 32'(ASTEP);
                  next_r.dst = r.dst + 32'(ASTEP);
               end else if (r.brem > 16'h0001) begin
                  next_r.arem = r.array_byte_count;
                  next_r.brem = r.brem - 16'h0001;
                  next_r.src = r.src_b + {{16{pword[W_BIDX][15]}},
                                          pword[W_BIDX][15:0]};
                  next_r.dst = r.dst_b + {{16{pword[W_BIDX][31]}},
                                          pword[W_BIDX][31:16]};
                  next_r.src_b = next_r.src;
                  next_r.dst_b = next_r.dst;
               end else if (r.frame_count > 16'h0001) begin
                  next_r.arem = r.array_byte_count;
                  next_r.brem = r.array_count;
                  next_r.frame_count = r.frame_count - 16'h0001;
                  next_r.src = r.src_b + {{16{pword[W_CIDX][15]}},
                                          pword[W_CIDX][15:0]};
                  next_r.dst = r.dst_b + {{16{pword[W_CIDX][31]}},
                                          pword[W_CIDX][31:16]};
                  next_r.src_b = next_r.src;
                  next_r.dst_b = next_r.dst;
               end else begin
                  next_r.mem_req.valid = 1'b0;
                  next_r.state = DONE;
               end
            end
         end
         DONE: begin
            next_r.status[r.chan] = 1'b1;
            if (pword[W_OPT][0]) begin
               next_r.pend[pword[W_OPT][6:1]] = 1'b1;
            end
            next_r.state = IDLE;
         end
      endcase
      next_r.xfer_owner = {1'b0, r.chan[0]};
      next_r.irq = |(next_r.status & r.mask);
      if (!rst_n) begin
         next_r = '0;
         next_r.evsel = EVSEL_RST;
         next_r.chirps = CHIRPS_RST;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      r <= next_r;
   end

   assign rdata = r.rdata;
   assign mem_req = r.mem_req;
   assign buf_waddr = r.buf_waddr;
   assign buf_wdata = r.buf_wdata;
   assign buf_we = r.buf_we;
   assign write_half = r.half;
   assign chirp_ready = r.chirp_ready;
   assign irq = r.irq;
endmodule // dmalc_top

// ### rtl/dmalc_pkg.sv
// package: constants, register map and carrier types for the dma block
package dmalc_pkg;
   localparam int unsigned CHANNELS      = 64;
   localparam int unsigned SETS_A        = 128;
   localparam int unsigned SETS_B        = 256;
   localparam int unsigned LINK_W        = 16;
   localparam int unsigned SET_BYTES     = 32;
   localparam int unsigned HALF_FULL_KB  = 32;
   localparam int unsigned HALF_DIRECT_KB = 16;
   localparam int unsigned BULK_W        = 128;
   localparam int unsigned BULK_MHZ      = 200;
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned RX_CHANNELS   = 4;
   localparam logic [15:0] LINK_NULL     = 16'hffff;
   // register byte addresses
   localparam logic [11:0] OFS_STATUS    = 12'h000;
   localparam logic [11:0] OFS_MASK      = 12'h004;
   localparam logic [11:0] OFS_SWTRIG    = 12'h008;
   localparam logic [11:0] OFS_EVSEL     = 12'h00c;
   localparam logic [11:0] OFS_BUFCTL    = 12'h010;
   localparam logic [11:0] OFS_BUFSTAT   = 12'h014;
   localparam logic [11:0] OFS_ACTIVE    = 12'h018;
   localparam logic [11:0] OFS_PARAMETER_TABLE     = 12'h800;
   // parameter set word indices
   localparam logic [2:0]  W_SRC   = 3'h0;
   localparam logic [2:0]  W_DST   = 3'h1;
   localparam logic [2:0]  W_CNT   = 3'h2;
   localparam logic [2:0]  W_FRM   = 3'h3;
   localparam logic [2:0]  W_BIDX  = 3'h4;
   localparam logic [2:0]  W_CIDX  = 3'h5;
   localparam logic [2:0]  W_LINK  = 3'h6;
   localparam logic [2:0]  W_OPT   = 3'h7;
   localparam logic [5:0]  EVSEL_RST  = 6'h00;
   localparam logic [7:0]  CHIRPS_RST = 8'h01;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [11:0] addr;
      logic [31:0] wdata;
   } dmalc_bus_type;

   typedef struct packed {
      logic         valid;
      logic         write;
      logic [31:0]  addr;
      logic [127:0] data;
      logic [15:0]  byte_en;
   } dmalc_mem_req_type;

   typedef struct packed {
      logic        valid;
      logic [1:0]  rx;
      logic        last_of_chirp;
      logic [31:0] data;
   } dmalc_sample_type;

   typedef enum logic [1:0] {
      IDLE, LOAD, MOVE, DONE
   } dmalc_state_type;
endpackage

// ### sim/dmalc_asserts.sv
// checker: port-level properties of the dma block
module dmalc_asserts
   import dmalc_pkg::*;
(
   input wire logic                         core_clk,
   input wire logic                         rst_n,
   input wire dmalc_pkg::dmalc_bus_type     bus,
   input wire logic [31:0]                  rdata,
   input wire dmalc_pkg::dmalc_sample_type  sample,
   input wire logic                         mem_ready,
   input wire dmalc_pkg::dmalc_mem_req_type mem_req,
   input wire logic [31:0]                  buf_wdata,
   input wire logic                         buf_we,
   input wire logic                         write_half,
   input wire logic                         chirp_ready,
   input wire logic                         irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence stalled;
      mem_req.valid && !mem_ready;
   endsequence
   sequence held;
      mem_req.valid && $stable(mem_req.addr);
   endsequence
   a_rdata_quiet: assert property (!$past(bus.read) |-> rdata == 32'h0)
      else $error("read data outside its cycle");
   a_sample_write: assert property (sample.valid |=>
      buf_we && buf_wdata == $past(sample.data))
      else $error("sample not written next cycle");
   a_write_quiet: assert property (!sample.valid |=> !buf_we)
      else $error("buffer write without sample");
   a_ready_pulse: assert property (chirp_ready |=> !chirp_ready)
      else $error("chirp ready longer than a cycle");
   a_swap_on_ready: assert property (
      chirp_ready |-> write_half != $past(write_half))
      else $error("half not swapped with chirp ready");
   a_half_steady: assert property (
      !chirp_ready |-> $stable(write_half))
      else $error("half swapped without chirp ready");
   a_req_hold: assert property (stalled |=> held)
      else $error("request dropped before ready");
   a_mask_off: assert property (($past(bus.write)
      && $past(bus.addr) == OFS_MASK && $past(bus.wdata) == 32'h0) |=> !irq)
      else $error("irq high with mask cleared");
endmodule // dmalc_asserts
//////////////////////////////////////////////////////////////////////////////
bind dmalc_top dmalc_asserts chk_u (.core_clk, .rst_n, .bus, .rdata,
   .sample, .mem_ready, .mem_req, .buf_wdata, .buf_we, .write_half,
   .chirp_ready, .irq);

// ### sim/dmalc_mem_model.sv
// model: bulk memory that accepts requests after a chosen wait
module dmalc_mem_model
   import dmalc_pkg::*;
(
   input  wire logic                         core_clk,
   input  wire logic                         rst_n,
   input  wire dmalc_pkg::dmalc_mem_req_type mem_req,
   input  wire logic [1:0]                   lat,
   output      logic                         mem_ready
);
   logic [1:0] waited;
   // one 16-byte beat per ready cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n || !mem_req.valid || mem_ready) begin
         waited <= 2'h0;
      end else begin
         waited <= waited + 2'h1;
      end
   end
   // lat of zero answers at once, larger values stall
   assign mem_ready = mem_req.valid && waited >= lat;
endmodule // dmalc_mem_model

// ### sim/dmalc_top_test.sv
// testbench: self-checking run of the dma block
module dmalc_top_test
   import dmalc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic              core_clk, rst_n, hw_event, mem_ready, irq;
   logic              buf_we, write_half, chirp_ready;
   logic [1:0]        lat;
   logic [31:0]       rdata, buf_wdata, d, seed, src;
   logic [12:0]       buf_waddr;
   dmalc_bus_type     bus;
   dmalc_sample_type  sample;
   dmalc_mem_req_type mem_req;
   int                failures, compares, pulses, a, c;
   logic [31:0]       q[$];
   logic [12:0]       wq[$];
   logic [11:0]       ra[6] = '{OFS_STATUS, OFS_MASK, OFS_EVSEL,
                                OFS_BUFCTL, OFS_BUFSTAT, 12'h7fc};
   logic [31:0]       rv[6] = '{0, 0, EVSEL_RST, CHIRPS_RST, 0, 0};
   dmalc_top #(.CHIRP_SAMPLES(4)) dut_u (.core_clk, .rst_n, .bus, .rdata,
      .sample, .hw_event, .mem_ready, .mem_req, .buf_waddr, .buf_wdata,
      .buf_we, .write_half, .chirp_ready, .irq);
   dmalc_mem_model mem_u (.core_clk, .rst_n, .mem_req, .lat, .mem_ready);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (chirp_ready) pulses++;
      if (mem_req.valid && mem_ready) q.push_back(mem_req.addr);
      if (buf_we) wq.push_back(buf_waddr);
   end
   // rx-major slot: 2 chirps per half, 4 samples per chirp
   function automatic logic [12:0] buf_addr(int rx, int ch, int s);
      return 13'((rx * 2 + ch) * 4 + s);
   endfunction
   //////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [11:0] ad, logic [31:0] v);
      bus <= '{1'b1, 1'b0, ad, v};
      @(posedge core_clk);
      bus <= '0;
      @(posedge core_clk);
   endtask
   // read data stand one cycle only, so sample just after the edge
   task automatic rd(logic [11:0] ad);
      bus <= '{1'b0, 1'b1, ad, 32'h0};
      @(posedge core_clk);
      bus <= '0;
      #1 d = rdata;
      @(posedge core_clk);
      #1;
   endtask
   task automatic prog(int ch, logic [31:0] s, logic [15:0] lk, int op);
      logic [31:0] w[8];
      w = '{s, s + 32'h1000, 32'h0001_0010, 1, 0, 0, {16'h0, lk}, op};
      for (int i = 0; i < 8; i++) wr(12'(OFS_PARAMETER_TABLE + ch * 32 + i * 4), w[i]);
   endtask
   task automatic go(int ch);
      lat <= 2'($random(seed));
      q.delete();
      wr(OFS_SWTRIG, ch);
   endtask
   task automatic wait_st(logic [31:0] m);
      int n;
      n = 0;
      do begin
         rd(OFS_STATUS);
         n++;
      end while ((d & m) !== m && n < 100);
      chk("status", m, d & m);
   endtask
   task automatic give_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      give_verdict;
   end
   initial begin
      seed = 32'h15701b53;
      rst_n = 1'b0; bus = '0; sample = '0; hw_event = 1'b0; lat = 2'h0;
      failures = 0; compares = 0; pulses = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      foreach (ra[i]) begin
         rd(ra[i]);
         chk("reset value", rv[i], d);
      end
      wr(12'h7fc, 32'hffffffff);
      rd(12'h7fc);
      chk("unmapped", 0, d);
      $display("test reset done");
      wr(OFS_MASK, 32'hffffffff);
      a = $unsigned($random(seed)) % 30;
      src = $random(seed) & 32'hffff_fff0;
      prog(a + 1, src ^ 32'h100, 16'hffff, 0);
      prog(a, src, 16'hffff, ((a + 1) << 1) | 1);
      go(a);
      wait_st(3 << a);
      chk("first beat", src, q[0]);
      chk("chained beat", src ^ 32'h100, q[q.size() - 1]);
      chk("irq", 1, irq);
      wr(OFS_STATUS, 3 << a);
      rd(OFS_STATUS);
      chk("cleared", 0, d);
      chk("irq", 0, irq);
      $display("test chain done");
      c = (a + 5) % 32;
      prog(c, src + 32'h40, 16'hffff, 0);
      wr(OFS_MASK, 0);
      wr(OFS_EVSEL, c);
      hw_event <= 1'b1;
      @(posedge core_clk);
      hw_event <= 1'b0;
      wait_st(1 << c);
      chk("masked irq", 0, irq);
      wr(OFS_STATUS, 1 << c);
      $display("test event done");
      prog(c, src + 32'h80, 16'hffff, 0);
      wr(OFS_BUFCTL, 2);
      q.delete();
      wq.delete();
      for (int k = 1; k <= 4; k++) begin
         for (int i = 0; i < 4; i++) begin
            sample <= '{1'b1, 2'(i), i == 3, $random(seed)};
            @(posedge core_clk);
         end
         sample <= '0;
         repeat (3) @(posedge core_clk);
         #1;
         chk("chirp ready", k / 2, pulses);
         chk("write half", (k / 2) % 2, write_half);
      end
      chk("buffer writes", 16, wq.size());
      chk("buffer addr", buf_addr(0, 1, 0), wq[4]);
      chk("buffer addr", buf_addr(0, 0, 0), wq[8]);
      wait_st(1 << c);
      chk("chirp beat", src + 32'h80, q[0]);
      $display("test buffer done");
      prog(62, src + 32'h200, 16'hffff, 0);
      prog(a, src, 16'(62 * 32), 0);
      wr(OFS_STATUS, 32'hffffffff);
      go(a);
      wait_st(1 << a);
      wr(OFS_STATUS, 1 << a);
      go(a);
      wait_st(1 << a);
      chk("linked beat", src + 32'h200, q[0]);
      $display("test link done");
      give_verdict;
   end
endmodule // dmalc_top_test
